//--- core/sad_decoder.v
// Purpose: classify host physical addresses and form PCI addresses
// Assumes: one request per cycle, inputs synchronous to sys_clk
// Notes: answer is registered, one cycle after the request
`timescale 1ns/10ps
`include "sad_map.vh"

module sad_decoder #(
  parameter AW = 40,
  parameter PW = 64
) (
  input wire sys_clk,
  input wire rst,
  input wire reqValid,
  input wire [AW-1:0] reqAddr,
  input wire reqWrite,
  input wire byteWordEnable,
  input wire [31:0] sparseMemHighExtension,
  input wire [31:0] sparseIoHighExtension,
  output reg rspValid_q,
  output reg [4:0] rspTarget_q,
  output reg [2:0] rspCsrGroup_q,
  output reg rspUnmapped_q,
  output reg rspForward_q,
  output reg [PW-1:0] rspPciAddr_q,
  output reg [1:0] rspSize_q,
  output reg rspSizeValid_q,
  output reg rspFlashBadSize_q,
  output reg rspWrite_q
);

  // ==========================================================
  // region overview
  // cached half (bit 39 clear):
  //   00-01 main memory, 0E dummy region, rest unmapped
  // noncached half, segment from bits 35:32 (38:36 ignored):
  //   0-3 sparse memory region 0, 512MB window
  //   4 sparse memory region 1, 128MB window
  //   5 lower half sparse memory region 2, 64MB window
  //   5 third quarter sparse I/O A, fixed at the bottom
  //   5 top quarter sparse I/O B, relocatable
  //   6 dense memory, 4GB straight through
  //   7 split in quarters of 0.25GB by bits 31:28:
  //     0-1 sparse configuration
  //     2-3 special cycle or interrupt acknowledge
  //     4-6, 8-A control-register groups in order
  //     7 and B reserved, answered as unmapped
  //     C-F flash in the byte/word map, else reserved
  //   8-B byte/word map only: memory, I/O, cfg type 0, cfg type 1
  //   C-F unmapped in both maps
  // the segment alias means two host addresses that differ only
  // in bits 38:36 always reach the same target; software must not
  // expect distinct aliases to reach distinct devices
  // size bits 38:37 reach the size output only in the byte/word map, and
  // are marked valid only for noncached requests; the noncached decode ignores them
  // unmapped requests still answer, with forwarding held low and a
  // zero PCI address, so the host side never waits on a hole
  // the answer is one register stage deep: every decision is made
  // combinationally from the request and registered on the same
  // edge, trading a longer path for a fixed one-cycle latency

  // ==========================================================
  // field extraction
  // aliased range ignores bits 38:36, so segment is 35:32 only
  wire noncached;
  wire ioTop;
  wire [3:0] seg;
  wire [3:0] quarter;
  wire [1:0] half;
  wire [1:0] sizeBits;

  assign noncached = reqAddr[`SAD_NONCACHED];
  assign ioTop = (reqAddr[39:36] & 4'h8) == `SAD_IO_TOP;
  assign seg = reqAddr[35:32];
  assign quarter = reqAddr[31:28];
  assign half = reqAddr[31:30];
  assign sizeBits = reqAddr[38:37];

  // ==========================================================
  // target decode
  reg [4:0] tgt_d;
  reg [2:0] csrGrp_d;

  // one pass picks exactly one target; fallthrough is unmapped
  always @* begin
    tgt_d = `SAD_TGT_NONE;
    csrGrp_d = `SAD_CSR_MAIN;
    if (!noncached) begin
      // cached space: main memory and the dummy region only
      if (reqAddr[38:32] == `SAD_MAIN_HI || reqAddr[38:32] == 7'h01) begin
        tgt_d = `SAD_TGT_MAIN;
      end else if (reqAddr[39:32] == `SAD_DUMMY_HI) begin
        tgt_d = `SAD_TGT_DUMMY;
      end
    end else if (ioTop || byteWordEnable) begin
      case (seg)
        4'h0, 4'h1, 4'h2, 4'h3: begin
          tgt_d = `SAD_TGT_SMEM0;
        end
        `SAD_SEG_SMEM1: begin
          tgt_d = `SAD_TGT_SMEM1;
        end
        `SAD_SEG_MIX: begin
          if (half == `SAD_H_SMEM2 || half == `SAD_H_SMEM2B) begin
            tgt_d = `SAD_TGT_SMEM2;
          end else if (half == `SAD_H_SIOA) begin
            tgt_d = `SAD_TGT_SIOA;
          end else begin
            tgt_d = `SAD_TGT_SIOB;
          end
        end
        `SAD_SEG_DENSE: begin
          tgt_d = `SAD_TGT_DENSE;
        end
        `SAD_SEG_CTRL: begin
          if (quarter == `SAD_Q_CFG0 || quarter == `SAD_Q_CFG1) begin
            tgt_d = `SAD_TGT_SCFG;
          end else if (quarter == `SAD_Q_SPEC0 || quarter == `SAD_Q_SPEC1) begin
            tgt_d = `SAD_TGT_SPEC;
          end else if (quarter >= `SAD_Q_CSR_LO && quarter <= `SAD_Q_CSR_HI
                       && quarter != `SAD_Q_RSV) begin
            tgt_d = `SAD_TGT_CSR;
            csrGrp_d = quarter[2:0] - 3'h4;
          end else if (byteWordEnable && quarter >= `SAD_Q_FLASH) begin
            tgt_d = `SAD_TGT_FLASH;
          end else begin
            tgt_d = `SAD_TGT_NONE;
          end
        end
        `SAD_SEG_BWMEM: begin
          if (byteWordEnable) begin
            tgt_d = `SAD_TGT_BWMEM;
          end
        end
        `SAD_SEG_BWIO: begin
          if (byteWordEnable) begin
            tgt_d = `SAD_TGT_BWIO;
          end
        end
        `SAD_SEG_BWCFG0: begin
          if (byteWordEnable) begin
            tgt_d = `SAD_TGT_BWCFG0;
          end
        end
        `SAD_SEG_BWCFG1: begin
          if (byteWordEnable) begin
            tgt_d = `SAD_TGT_BWCFG1;
          end
        end
        default: begin
          tgt_d = `SAD_TGT_NONE;
        end
      endcase
    end
  end

  // ==========================================================
  // PCI address formation
  reg [PW-1:0] pci_d;

  // sparse space drops host bits 4:0; upper PCI bits of sparse memory
  // and sparse I/O B come from the extension registers so those
  // windows can be relocated; sparse I/O A and configuration stay fixed
  always @* begin
    pci_d = {PW{1'b0}};
    case (tgt_d)
      `SAD_TGT_SMEM0: begin
        pci_d[28:0] = reqAddr[33:5];
        pci_d[31:29] = sparseMemHighExtension[`SAD_R0_EXT_HI:`SAD_R0_EXT_LO];
      end
      `SAD_TGT_SMEM1: begin
        pci_d[26:0] = reqAddr[31:5];
        pci_d[31:27] = sparseMemHighExtension[`SAD_R1_EXT_HI:`SAD_R1_EXT_LO];
      end
      `SAD_TGT_SMEM2: begin
        pci_d[25:0] = reqAddr[30:5];
        pci_d[31:26] = sparseMemHighExtension[`SAD_R2_EXT_HI:`SAD_R2_EXT_LO];
      end
      `SAD_TGT_SIOA: begin
        pci_d[24:0] = reqAddr[29:5]; // fixed at 0-32MB
      end
      `SAD_TGT_SIOB: begin
        pci_d[24:0] = reqAddr[29:5];
        pci_d[31:25] = sparseIoHighExtension[`SAD_IOB_EXT_HI:`SAD_IOB_EXT_LO];
      end
      `SAD_TGT_SCFG: begin
        pci_d[23:0] = reqAddr[28:5];
      end
      `SAD_TGT_DENSE, `SAD_TGT_BWMEM, `SAD_TGT_BWIO,
      `SAD_TGT_BWCFG0, `SAD_TGT_BWCFG1: begin
        pci_d[31:4] = reqAddr[31:4];
      end
      default: begin
        pci_d = {PW{1'b0}};
      end
    endcase
  end

  // ==========================================================
  // answer registers
  // forwarding covers everything the host bridge passes to PCI;
  // local targets (memory, csr, flash) are not forwarded
  wire forward_d;
  wire flashBad_d;

  assign forward_d = (tgt_d != `SAD_TGT_NONE) && (tgt_d != `SAD_TGT_MAIN)
                     && (tgt_d != `SAD_TGT_DUMMY) && (tgt_d != `SAD_TGT_CSR)
                     && (tgt_d != `SAD_TGT_FLASH);
  // flash misuse is flagged, not blocked: result stays undefined
  assign flashBad_d = (tgt_d == `SAD_TGT_FLASH) && (sizeBits != `SAD_SIZE_BYTE);

  // answer strobe follows each request by exactly one edge
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspValid_q <= 1'b0;
    end else begin
      rspValid_q <= reqValid;
    end
  end

  // target code holds until the next taken request
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspTarget_q <= `SAD_TGT_NONE;
    end else if (reqValid) begin
      rspTarget_q <= tgt_d;
    end
  end

  // group index only means something with the csr target
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspCsrGroup_q <= `SAD_CSR_MAIN;
    end else if (reqValid) begin
      rspCsrGroup_q <= csrGrp_d;
    end
  end

  // unmapped flag mirrors the none target
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspUnmapped_q <= 1'b0;
    end else if (reqValid) begin
      rspUnmapped_q <= (tgt_d == `SAD_TGT_NONE);
    end
  end

  // forwarding never set for holes or local targets
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspForward_q <= 1'b0;
    end else if (reqValid) begin
      rspForward_q <= forward_d;
    end
  end

  // PCI address registered so downstream sees a clean value
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspPciAddr_q <= {PW{1'b0}};
    end else if (reqValid) begin
      rspPciAddr_q <= pci_d;
    end
  end

  // size reads as byte when the byte/word map is off
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspSize_q <= `SAD_SIZE_BYTE;
    end else if (reqValid) begin
      rspSize_q <= byteWordEnable ? sizeBits : `SAD_SIZE_BYTE;
    end
  end

  // size is meaningful only for noncached byte/word requests
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspSizeValid_q <= 1'b0;
    end else if (reqValid) begin
      rspSizeValid_q <= byteWordEnable && noncached;
    end
  end

  // flash misuse flag
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspFlashBadSize_q <= 1'b0;
    end else if (reqValid) begin
      rspFlashBadSize_q <= flashBad_d;
    end
  end

  // direction travels with the answer
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspWrite_q <= 1'b0;
    end else if (reqValid) begin
      rspWrite_q <= reqWrite;
    end
  end

endmodule

//--- core/sad_map.vh
// Purpose: constants for the system address decoder
// Assumes: 40-bit host physical addresses, 64-bit PCI addresses
// Notes: target codes, field positions and window slices
//
// Behaviour
// - decode each 40-bit address to one target
// - form 64-bit PCI address from bits 33:4
// - control-one bit 0 selects decode map
// - bit clear: byte/word-disabled map, top reserved
// - bit set: byte/word map, same low decoding
// - 80.0-83.F is sparse memory region 0
// - 84.x is sparse memory region 1
// - 85.0-85.7 is sparse memory region 2
// - 85.8-85.B is sparse I/O region A
// - 85.C-85.F is sparse I/O region B
// - 87.0-87.1 is sparse configuration space
// - 87.4-87.A selects control-register groups in order
// - disabled map aliases whole 80-8F range
// - ignore bits 36-38 in aliased range
// - bit 39 splits cached and noncached space
// - byte/word mode: bits 38:37 give size
// - high extension supplies sparse memory upper bits
`ifndef SAD_MAP_VH
`define SAD_MAP_VH

// target codes
`define SAD_TGT_NONE 5'h00
`define SAD_TGT_MAIN 5'h01
`define SAD_TGT_DUMMY 5'h02
`define SAD_TGT_SMEM0 5'h03
`define SAD_TGT_SMEM1 5'h04
`define SAD_TGT_SMEM2 5'h05
`define SAD_TGT_SIOA 5'h06
`define SAD_TGT_SIOB 5'h07
`define SAD_TGT_DENSE 5'h08
`define SAD_TGT_SCFG 5'h09
`define SAD_TGT_SPEC 5'h0A
`define SAD_TGT_CSR 5'h0B
`define SAD_TGT_BWMEM 5'h0C
`define SAD_TGT_BWIO 5'h0D
`define SAD_TGT_BWCFG0 5'h0E
`define SAD_TGT_BWCFG1 5'h0F
`define SAD_TGT_FLASH 5'h10

// control-register groups within 87.4-87.A
`define SAD_CSR_MAIN 3'h0
`define SAD_CSR_MEMCTL 3'h1
`define SAD_CSR_XLAT 3'h2
`define SAD_CSR_MISC 3'h4
`define SAD_CSR_PWR 3'h5
`define SAD_CSR_INTR 3'h6

// address field values
`define SAD_NONCACHED 39
`define SAD_IO_TOP 4'h8
`define SAD_MAIN_HI 7'h00
`define SAD_DUMMY_HI 8'h0E
`define SAD_SEG_SMEM1 4'h4
`define SAD_SEG_MIX 4'h5
`define SAD_SEG_DENSE 4'h6
`define SAD_SEG_CTRL 4'h7
`define SAD_SEG_BWMEM 4'h8
`define SAD_SEG_BWIO 4'h9
`define SAD_SEG_BWCFG0 4'hA
`define SAD_SEG_BWCFG1 4'hB
`define SAD_Q_CFG0 4'h0
`define SAD_Q_CFG1 4'h1
`define SAD_Q_SPEC0 4'h2
`define SAD_Q_SPEC1 4'h3
`define SAD_Q_CSR_LO 4'h4
`define SAD_Q_CSR_HI 4'hA
`define SAD_Q_RSV 4'h7
`define SAD_Q_FLASH 4'hC
`define SAD_H_SMEM2 2'h0
`define SAD_H_SMEM2B 2'h1
`define SAD_H_SIOA 2'h2
`define SAD_SIZE_BYTE 2'h0

// extension register fields feeding PCI upper bits
`define SAD_R0_EXT_HI 31
`define SAD_R0_EXT_LO 29
`define SAD_R1_EXT_HI 15
`define SAD_R1_EXT_LO 11
`define SAD_R2_EXT_HI 7
`define SAD_R2_EXT_LO 2
`define SAD_IOB_EXT_HI 31
`define SAD_IOB_EXT_LO 25

`endif

//--- bench/sad_decoder_props.sv
// Purpose: port-level checks for the system address decoder
// Assumes: one clock domain, asynchronous active-high reset
// Notes: attached to every decoder instance by bind
`timescale 1ns/10ps
`include "sad_map.vh"
// ==========
// checker
module sad_decoder_props (
  input wire sys_clk,
  input wire rst,
  input wire reqValid,
  input wire [39:0] reqAddr,
  input wire reqWrite,
  input wire byteWordEnable,
  input wire rspValid_q,
  input wire [4:0] rspTarget_q,
  input wire rspUnmapped_q,
  input wire rspForward_q,
  input wire [63:0] rspPciAddr_q,
  input wire [1:0] rspSize_q,
  input wire rspSizeValid_q,
  input wire rspFlashBadSize_q,
  input wire rspWrite_q
);
  // size bits copied so that $past sees a plain signal
  wire [1:0] sizeBits = reqAddr[38:37];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a taken request and its answer one edge later
  sequence sTaken; reqValid; endsequence
  sequence sAnswer; rspValid_q; endsequence
  a_answer_one_cycle: assert property (sTaken |=> sAnswer)
    else $error("request without answer");
  a_no_spurious: assert property (!reqValid |=> !rspValid_q)
    else $error("answer without request");
  a_unmapped_code: assert property (sAnswer |-> (rspUnmapped_q == (rspTarget_q == 5'h00))
    && !(rspUnmapped_q && rspForward_q))
    else $error("unmapped flag wrong");
  a_pci_upper_zero: assert property (sAnswer |-> rspPciAddr_q[63:32] == 32'h0)
    else $error("pci upper bits set");
  a_idle_hold: assert property (!reqValid |=> $stable(rspTarget_q) && $stable(rspPciAddr_q))
    else $error("answer changed while idle");
  a_write_copy: assert property (sTaken |=> rspWrite_q == $past(reqWrite))
    else $error("direction not copied");
  a_main_decode: assert property (reqValid && reqAddr[39:33] == 7'h00
    |=> rspTarget_q == `SAD_TGT_MAIN)
    else $error("main memory missed");
  a_alias_smem0: assert property (reqValid && reqAddr[39] && reqAddr[35:34] == 2'h0
    |=> rspTarget_q == `SAD_TGT_SMEM0)
    else $error("sparse region zero missed");
  a_size_bw: assert property (reqValid && byteWordEnable && reqAddr[39]
    |=> rspSizeValid_q && rspSize_q == $past(sizeBits))
    else $error("size not reported");
  a_size_off: assert property (reqValid && !byteWordEnable
    |=> rspSize_q == 2'h0 && !rspSizeValid_q)
    else $error("size reported with map off");
  a_flash_flag: assert property (sAnswer ##0 (rspTarget_q == `SAD_TGT_FLASH)
    |-> rspFlashBadSize_q == (rspSize_q != 2'h0))
    else $error("flash size flag wrong");
endmodule
bind sad_decoder sad_decoder_props sad_decoder_props_i (.sys_clk, .rst, .reqValid, .reqAddr,
  .reqWrite, .byteWordEnable, .rspValid_q, .rspTarget_q, .rspUnmapped_q, .rspForward_q,
  .rspPciAddr_q, .rspSize_q, .rspSizeValid_q, .rspFlashBadSize_q, .rspWrite_q);

//--- bench/sad_host_model.sv
// Purpose: host processor issuing physical addresses
// Assumes: requests launched just after a rising edge
// Notes: size bits travel inside the address as the caller gives them
`timescale 1ns/10ps
// ==========
// host model
module sad_host_model (
  input wire sys_clk,
  output logic reqValid = 1'b0,
  output logic [39:0] reqAddr = 40'h0,
  output logic reqWrite = 1'b0,
  output logic byteWordEnable = 1'b0
);
  // one address per edge, held for that whole cycle
  task send(input [39:0] a, input w, input b);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqWrite <= w;
    byteWordEnable <= b;
  endtask
  // released bus shows the inverse so a stale address cannot pass
  task idle();
    @(posedge sys_clk);
    reqValid <= 1'b0;
    reqAddr <= ~reqAddr;
  endtask
endmodule

//--- bench/testbench.sv
// Purpose: self-checking bench for the system address decoder
// Assumes: answer one edge after each request
// Notes: corner table first, then seeded random traffic
`timescale 1ns/10ps
`include "sad_map.vh"
// ==========
// bench top
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] memExt = 32'h0;
  logic [31:0] ioExt = 32'h0;
  wire reqValid, reqWrite, byteWordEnable;
  wire [39:0] reqAddr;
  wire rspValid_q, rspUnmapped_q, rspForward_q, rspSizeValid_q, rspFlashBadSize_q, rspWrite_q;
  wire [4:0] rspTarget_q;
  wire [2:0] rspCsrGroup_q;
  wire [63:0] rspPciAddr_q;
  wire [1:0] rspSize_q;
  logic pV = 1'b0;
  logic pB, pW;
  logic [39:0] pA;
  logic [4:0] t;
  logic [63:0] r;
  integer seed = 85637;
  integer n_errors = 0;
  integer n_checks = 0;
  integer i;
  // {map bit, address}: region edges, every control group, reserved holes
  logic [40:0] corner [0:25] = '{41'h08580000040, 41'h083FFFFFFFF, 41'h08400000000,
    41'h0857FFFFFFF, 41'h085BFFFFFFF, 41'h085C0000000, 41'h0871FFFFFFF, 41'h08720000000,
    41'h08740000000, 41'h08750000000, 41'h08760000000, 41'h08770000000, 41'h08780000000,
    41'h08790000000, 41'h087A0000000, 41'h087B0000000, 41'h087C0000000, 41'h187C0000000,
    41'h1C7C0000000, 41'h18800000000, 41'h18B00000000, 41'h08900000000, 41'h001FFFFFFFF,
    41'h00200000000, 41'h00E00000000, 41'h1F600000010};
  always #25 sys_clk = ~sys_clk;
  sad_host_model sad_host_model_i (.sys_clk(sys_clk), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqWrite(reqWrite), .byteWordEnable(byteWordEnable));
  sad_decoder sad_decoder_i (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid),
    .reqAddr(reqAddr), .reqWrite(reqWrite), .byteWordEnable(byteWordEnable),
    .sparseMemHighExtension(memExt), .sparseIoHighExtension(ioExt), .rspValid_q(rspValid_q),
    .rspTarget_q(rspTarget_q), .rspCsrGroup_q(rspCsrGroup_q), .rspUnmapped_q(rspUnmapped_q),
    .rspForward_q(rspForward_q), .rspPciAddr_q(rspPciAddr_q), .rspSize_q(rspSize_q),
    .rspSizeValid_q(rspSizeValid_q), .rspFlashBadSize_q(rspFlashBadSize_q),
    .rspWrite_q(rspWrite_q));
  // target expected for one address under one map
  function automatic [4:0] expTarget(input [39:0] a, input b);
    logic [3:0] q;
    q = a[31:28];
    expTarget = `SAD_TGT_NONE;
    if (!a[39]) begin
      if (a[38:33] == 6'h00) expTarget = `SAD_TGT_MAIN;
      else if (a[38:32] == 7'h0E) expTarget = `SAD_TGT_DUMMY;
    end else case (a[35:32])
      4'h0, 4'h1, 4'h2, 4'h3: expTarget = `SAD_TGT_SMEM0;
      4'h4: expTarget = `SAD_TGT_SMEM1;
      4'h5: expTarget = a[31] ? (a[30] ? `SAD_TGT_SIOB : `SAD_TGT_SIOA) : `SAD_TGT_SMEM2;
      4'h6: expTarget = `SAD_TGT_DENSE;
      4'h7: if (q < 4'h2) expTarget = `SAD_TGT_SCFG;
        else if (q < 4'h4) expTarget = `SAD_TGT_SPEC;
        else if (q < 4'hB && q != 4'h7) expTarget = `SAD_TGT_CSR;
        else if (q > 4'hB && b) expTarget = `SAD_TGT_FLASH;
      default: if (b && a[35:34] == 2'h2) expTarget = 5'h0C + {3'h0, a[33:32]};
    endcase
  endfunction
  task chk(input [63:0] seen, input [63:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // remember each request so its answer is judged one edge later
  always @(posedge sys_clk) begin
    pV <= reqValid;
    pA <= reqAddr;
    pB <= byteWordEnable;
    pW <= reqWrite;
  end
  // judge answers mid-cycle, once the edge's updates have landed
  always @(negedge sys_clk) begin
    if (pV === 1'b1) begin
      t = expTarget(pA, pB);
      chk(rspTarget_q, t);
      chk(rspUnmapped_q, t == `SAD_TGT_NONE);
      chk(rspForward_q, t > 5'h02 && t != `SAD_TGT_CSR && t != `SAD_TGT_FLASH);
      chk(rspWrite_q, pW);
      chk(rspSize_q, pB ? pA[38:37] : 2'h0);
      chk(rspPciAddr_q[63:32], 32'h0);
      if (t == `SAD_TGT_SIOA) chk(rspPciAddr_q, pA[29:5]);
      if (t == `SAD_TGT_DENSE) chk(rspPciAddr_q, {pA[31:4], 4'h0});
      if (t == `SAD_TGT_CSR) chk(rspCsrGroup_q, pA[31:28] - 4'h4);
      chk(rspSizeValid_q, pB && pA[39]);
      chk(rspFlashBadSize_q, t == `SAD_TGT_FLASH && pA[38:37] != 2'h0);
      if (t == `SAD_TGT_SMEM0) chk(rspPciAddr_q, {memExt[31:29], pA[33:5]});
      if (t == `SAD_TGT_SMEM1) chk(rspPciAddr_q, {memExt[15:11], pA[31:5]});
      if (t == `SAD_TGT_SMEM2) chk(rspPciAddr_q, {memExt[7:2], pA[30:5]});
      if (t == `SAD_TGT_SIOB) chk(rspPciAddr_q, {ioExt[31:25], pA[29:5]});
      if (t == `SAD_TGT_SCFG) chk(rspPciAddr_q, pA[28:5]);
    end
  end
  // main sequence: corners back to back, then random traffic with gaps
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    memExt <= $random(seed);
    ioExt <= $random(seed);
    for (i = 0; i < 26; i = i + 1) sad_host_model_i.send(corner[i][39:0], i[0], corner[i][40]);
    for (i = 0; i < 400; i = i + 1) begin
      r = {$random(seed), $random(seed)};
      r[35:32] = r[42] ? 4'h7 : r[35:32];
      if (r[43]) sad_host_model_i.idle();
      sad_host_model_i.send(r[39:0], r[44], r[45]);
    end
    sad_host_model_i.idle();
    repeat (3) @(posedge sys_clk);
    print_verdict;
  end
  // watchdog well beyond the at most 835 cycles the tests need
  initial begin
    #(3000 * 50);
    n_errors = n_errors + 1;
    print_verdict;
  end
endmodule
